// ===== src/urf_pkg.sv
`default_nettype none
package urf_pkg;
   // ***********************************
   // register map (byte addresses)
   // ***********************************
   localparam logic [7:0] A_DATA = 8'h00;
   localparam logic [7:0] A_IEN = 8'h04;
   localparam logic [7:0] A_ISRC = 8'h08;
   localparam logic [7:0] A_FCTL = 8'h0C;
   localparam logic [7:0] A_LSTAT = 8'h10;
   localparam logic [7:0] A_MSTAT = 8'h14;
   localparam logic [7:0] A_DIV = 8'h18;
   localparam logic [7:0] A_FLOW = 8'h1C;
   localparam logic [7:0] A_PCHR = 8'h20;
   localparam logic [7:0] A_RCHR = 8'h24;
   localparam logic [7:0] A_TRIGD = 8'h28;
   // ***********************************
   // fields and reset values
   // ***********************************
   localparam int IEN_RXD = 0;
   localparam int IEN_SLEEP = 4;
   localparam int IEN_PAUSE = 5;
   localparam int FCTL_EN = 0;
   localparam int FLOW_EN = 0;
   localparam int FLOW_DBL = 1;
   localparam int FLOW_AUTO = 2;
   localparam int ISRC_FC = 4;
   localparam logic [3:0] ISRC_NONE = 4'h1;
   localparam logic [3:0] ISRC_RXD = 4'h4;
   localparam logic [3:0] ISRC_FCI = 4'h0;
   localparam logic [7:0] CHR_RST = 8'h00;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   localparam logic [1:0] TBL_D = 2'h3;
   // ***********************************
   // timing
   // ***********************************
   localparam longint CLK_HZ = 125000000;
   localparam longint IDLE_S = 30;
   localparam longint IDLE_CYC = IDLE_S * CLK_HZ;
   localparam longint RECOVER_US = 45;
   localparam longint RECOVER_CYC = (RECOVER_US * CLK_HZ + 999999) / 1000000;
   localparam int OVERSAMPLE = 16;
   localparam int CHAR_BITS = 10;
   localparam int TWO_CHAR_MUL = 2 * CHAR_BITS * OVERSAMPLE;
   // ***********************************
   // types
   // ***********************************
   typedef struct packed {
      logic [2:0] err;
      logic [7:0] data;
   } urf_char_type;
   typedef enum logic [1:0] {SL_AWAKE = 2'b01, SL_ASLEEP = 2'b10} urf_sleep_type;
   typedef enum logic [2:0] {AP_IDLE = 3'b001, AP_WAIT = 3'b010, AP_SEND = 3'b100} urf_auto_type;
endpackage
`default_nettype wire

// ===== src/urf_uart_rx_fc_sleep.sv
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`default_nettype none
module urf_uart_rx_fc_sleep
  import urf_pkg::*;
#(
   parameter int DEPTH = 64,
   parameter longint IDLE_CYCLES = IDLE_CYC,
   parameter longint RECOVER_CYCLES = RECOVER_CYC
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // register bus
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // receive source for channel b
   input wire logic RX_SOURCE_SELECT,
   input wire logic LINE_RX_DATA,
   input wire logic CHANNEL_B_RECEIVE_INPUT,
   output logic RX_SERIAL_B,
   output logic LINE_RX_TRISTATE,
   // characters from the receive shift register
   input wire urf_pkg::urf_char_type RX_CHAR,
   input wire logic RX_CHAR_VALID,
   // transmitter side
   output logic [7:0] TX_HOLD_DATA,
   output logic TX_HOLD_WRITE,
   output logic TX_HALT,
   output logic [7:0] TX_FC_CHAR,
   output logic TX_FC_VALID,
   input wire logic TX_FC_TAKEN,
   input wire logic TX_ACTIVE,
   // modem inputs and power
   input wire logic [3:0] MODEM_IN,
   input wire logic PUMP_SHUTDOWN_ENABLE_PIN,
   output logic OSC_RUN,
   output logic PUMP_ON,
   output logic PUMP_READY,
   output logic LINE_DRV_OE_N,
   output logic INT_OUT
);
   import urf_pkg::*;

   // ***********************************
   // registers
   // ***********************************
   logic [7:0] ien_ff, fctl_ff, flow_ff, trigd_ff;
   logic [15:0] div_ff, pchr_ff, rchr_ff;
   logic [3:0] msr_ff, modem_ff;
   logic fc_flag_ff, wake_int_ff;
   urf_char_type mem [DEPTH];
   logic [5:0] wptr_ff, rptr_ff;
   logic [6:0] cnt_ff;
   logic aw_v_ff, w_v_ff, bvalid_ff, rvalid_ff;
   logic [7:0] aw_a_ff;
   logic [31:0] w_d_ff, rdata_ff;
   logic [3:0] w_s_ff;
   logic [1:0] bresp_ff, rresp_ff;
   urf_sleep_type sl_ff;
   urf_auto_type ap_ff;

   // ***********************************
   // receive source and start edge
   // ***********************************
   logic rx_prev_ff, rx_fall;
   assign RX_SERIAL_B = RX_SOURCE_SELECT ? CHANNEL_B_RECEIVE_INPUT : LINE_RX_DATA;
   assign LINE_RX_TRISTATE = RX_SOURCE_SELECT;
   assign rx_fall = rx_prev_ff & ~RX_SERIAL_B;
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rx_prev_ff <= 1'b1;
         modem_ff <= 4'h0;
      end else begin
         rx_prev_ff <= RX_SERIAL_B;
         modem_ff <= MODEM_IN;
      end
   end

   // ***********************************
   // bus slave
   // ***********************************
   logic wr_go, rd_go;
   logic [7:0] wa;
   logic [31:0] wd, rd_val;
   logic rd_ok, wr_ok;
   assign S_AXI_AWREADY = ~aw_v_ff & ~bvalid_ff;
   assign S_AXI_WREADY = ~w_v_ff & ~bvalid_ff;
   assign S_AXI_ARREADY = ~rvalid_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign S_AXI_RRESP = rresp_ff;
   assign wr_go = aw_v_ff & w_v_ff & ~bvalid_ff;
   assign wa = aw_a_ff;
   assign wd = w_d_ff;
   assign rd_go = S_AXI_ARVALID & ~rvalid_ff;
   assign wr_ok = wa <= A_TRIGD && wa[1:0] == 2'h0;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         aw_v_ff <= 1'b0;
         w_v_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OK;
         aw_a_ff <= 8'h00;
         w_d_ff <= 32'h0;
         w_s_ff <= 4'h0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_v_ff <= 1'b1;
            aw_a_ff <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_v_ff <= 1'b1;
            w_d_ff <= S_AXI_WDATA;
            w_s_ff <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            aw_v_ff <= 1'b0;
            w_v_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? RESP_OK : RESP_ERR;
         end else if (bvalid_ff && S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // config registers; 16-bit ones honour both byte lanes
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ien_ff <= 8'h00;
         fctl_ff <= 8'h00;
         flow_ff <= 8'h00;
         trigd_ff <= 8'h00;
         div_ff <= 16'h0000;
         pchr_ff <= {CHR_RST, CHR_RST};
         rchr_ff <= {CHR_RST, CHR_RST};
      end else if (wr_go) begin
         if (w_s_ff[0]) begin
            case (wa)
               A_IEN: ien_ff <= wd[7:0];
               A_FCTL: fctl_ff <= wd[7:0];
               A_FLOW: flow_ff <= wd[7:0];
               A_TRIGD: trigd_ff <= wd[7:0];
               A_DIV: div_ff[7:0] <= wd[7:0];
               A_PCHR: pchr_ff[7:0] <= wd[7:0];
               A_RCHR: rchr_ff[7:0] <= wd[7:0];
               default: ;
            endcase
         end
         if (w_s_ff[1]) begin
            case (wa)
               A_DIV: div_ff[15:8] <= wd[15:8];
               A_PCHR: pchr_ff[15:8] <= wd[15:8];
               A_RCHR: rchr_ff[15:8] <= wd[15:8];
               default: ;
            endcase
         end
      end
   end

   // transmit holding write is forwarded as a one-cycle strobe
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         TX_HOLD_WRITE <= 1'b0;
         TX_HOLD_DATA <= 8'h00;
      end else begin
         TX_HOLD_WRITE <= wr_go && wa == A_DATA && w_s_ff[0];
         if (wr_go && wa == A_DATA && w_s_ff[0]) begin
            TX_HOLD_DATA <= wd[7:0];
         end
      end
   end

   // ***********************************
   // trigger tables
   // ***********************************
   // tables a-c share the b steps; d uses a programmed level and hysteresis
   function automatic logic [6:0] trig_lvl(input logic [7:0] f, input logic [7:0] td);
      logic [6:0] t;
      t = 7'd8;
      if (f[5:4] == TBL_D) begin
         t = td[6:0];
      end else begin
         case (f[7:6])
            2'h0: t = 7'd8;
            2'h1: t = 7'd16;
            2'h2: t = 7'd24;
            default: t = 7'd28;
         endcase
      end
      return t;
   endfunction

   logic [6:0] trig, hyst;
   logic over_trig, under_res;
   assign trig = trig_lvl(fctl_ff, trigd_ff);
   assign hyst = (fctl_ff[5:4] == TBL_D) ? {3'h0, fctl_ff[3:1], 1'b0} : 7'd0;
   assign over_trig = cnt_ff >= trig;
   // table b: resume one step below, so 8 resumes at 0 and 28 at 24
   always_comb begin
      under_res = 1'b0;
      if (fctl_ff[5:4] == TBL_D) begin
         under_res = {1'b0, cnt_ff} < {1'b0, trig} - {1'b0, hyst};
      end else begin
         case (fctl_ff[7:6])
            2'h0: under_res = cnt_ff == 7'd0;
            2'h1: under_res = cnt_ff <= 7'd8;
            2'h2: under_res = cnt_ff <= 7'd16;
            default: under_res = cnt_ff <= 7'd24;
         endcase
      end
   end

   // ***********************************
   // in-band match and fifo write path
   // ***********************************
   // double mode holds a possible first character back until the next character arrives;
   // it lands in the fifo only if the second does not complete the pair
   urf_char_type pend_ff, defer_ff, push_d;
   logic pend_v_ff, defer_v_ff, push, nxt_pend_v, nxt_defer_v, p_hit, r_hit;
   logic is_first;
   assign is_first = RX_CHAR.data == pchr_ff[7:0] || RX_CHAR.data == rchr_ff[7:0];
   always_comb begin
      push = defer_v_ff;
      push_d = defer_ff;
      p_hit = 1'b0;
      r_hit = 1'b0;
      nxt_pend_v = pend_v_ff;
      nxt_defer_v = 1'b0;
      if (RX_CHAR_VALID) begin
         if (!flow_ff[FLOW_EN]) begin
            push = 1'b1;
            push_d = RX_CHAR;
         end else if (!flow_ff[FLOW_DBL]) begin
            p_hit = RX_CHAR.data == pchr_ff[7:0];
            r_hit = !p_hit && RX_CHAR.data == rchr_ff[7:0];
            push = !(p_hit || r_hit);
            push_d = RX_CHAR;
         end else begin
            p_hit = pend_v_ff && pend_ff.data == pchr_ff[7:0]
                    && RX_CHAR.data == pchr_ff[15:8];
            r_hit = pend_v_ff && pend_ff.data == rchr_ff[7:0]
                    && RX_CHAR.data == rchr_ff[15:8];
            nxt_pend_v = 1'b0;
            if (!(p_hit || r_hit)) begin
               if (pend_v_ff) begin
                  push = 1'b1;
                  push_d = pend_ff;
               end
               if (is_first) begin
                  nxt_pend_v = 1'b1;
               end else if (pend_v_ff) begin
                  nxt_defer_v = 1'b1;
               end else begin
                  push = 1'b1;
                  push_d = RX_CHAR;
               end
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         pend_v_ff <= 1'b0;
         defer_v_ff <= 1'b0;
         pend_ff <= '0;
         defer_ff <= '0;
      end else begin
         pend_v_ff <= nxt_pend_v & flow_ff[FLOW_EN] & flow_ff[FLOW_DBL];
         defer_v_ff <= nxt_defer_v;
         if (RX_CHAR_VALID) begin
            pend_ff <= RX_CHAR;
            defer_ff <= RX_CHAR;
         end
      end
   end

   // pause wins if both arrive together; resume only acts while paused
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         fc_flag_ff <= 1'b0;
      end else if (p_hit) begin
         fc_flag_ff <= 1'b1;
      end else if (r_hit) begin
         fc_flag_ff <= 1'b0;
      end
   end
   assign TX_HALT = fc_flag_ff;

   // ***********************************
   // receive fifo
   // ***********************************
   logic pop, do_push, fifo_en;
   logic [6:0] cap;
   assign fifo_en = fctl_ff[FCTL_EN];
   assign cap = fifo_en ? 7'(DEPTH) : 7'd1;
   assign pop = rd_go && S_AXI_ARADDR == A_DATA && cnt_ff != 7'd0;
   assign do_push = push && (cnt_ff < cap || pop);
   always_ff @(posedge SYS_CLK) begin
      if (do_push) begin
         mem[wptr_ff] <= push_d;
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         wptr_ff <= 6'h0;
         rptr_ff <= 6'h0;
         cnt_ff <= 7'h0;
      end else begin
         wptr_ff <= wptr_ff + 6'(do_push);
         rptr_ff <= rptr_ff + 6'(pop);
         cnt_ff <= cnt_ff + 7'(do_push) - 7'(pop);
      end
   end

   // ***********************************
   // interrupt status and modem changes
   // ***********************************
   logic rxd_int, fc_int, pending, wake_ev, modem_rise;
   logic [3:0] modem_chg;
   assign modem_chg = modem_ff ^ MODEM_IN;
   assign modem_rise = |(MODEM_IN & ~modem_ff);
   assign rxd_int = ien_ff[IEN_RXD] && over_trig && cnt_ff != 7'd0;
   assign fc_int = ien_ff[IEN_PAUSE] && fc_flag_ff;
   assign pending = rxd_int | fc_int | wake_int_ff;
   assign INT_OUT = pending;

   // a change in the cycle of the status read is kept, not lost
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         msr_ff <= 4'h0;
      end else if (rd_go && S_AXI_ARADDR == A_MSTAT) begin
         msr_ff <= modem_chg;
      end else begin
         msr_ff <= msr_ff | modem_chg;
      end
   end

   always_comb begin
      rd_ok = 1'b1;
      rd_val = 32'h0;
      case (S_AXI_ARADDR)
         A_DATA: rd_val = {24'h0, mem[rptr_ff].data};
         A_IEN: rd_val = {24'h0, ien_ff};
         A_ISRC: rd_val = {27'h0, fc_flag_ff,
                           fc_int ? ISRC_FCI : rxd_int ? ISRC_RXD : ISRC_NONE};
         A_FCTL: rd_val = {24'h0, fctl_ff};
         A_LSTAT: rd_val = {27'h0, cnt_ff != 7'd0 ? mem[rptr_ff].err : 3'h0, 1'b0,
                            cnt_ff != 7'd0};
         A_MSTAT: rd_val = {24'h0, MODEM_IN, msr_ff};
         A_DIV: rd_val = {16'h0, div_ff};
         A_FLOW: rd_val = {24'h0, flow_ff};
         A_PCHR: rd_val = {16'h0, pchr_ff};
         A_RCHR: rd_val = {16'h0, rchr_ff};
         A_TRIGD: rd_val = {24'h0, trigd_ff};
         default: rd_ok = 1'b0;
      endcase
   end
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= RESP_OK;
      end else if (rd_go) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_val;
         rresp_ff <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (S_AXI_RREADY) begin
         rvalid_ff <= 1'b0;
      end
   end

   // ***********************************
   // sleep
   // ***********************************
   logic can_sleep;
   assign wake_ev = rx_fall | (wr_go && wa == A_DATA) | (|modem_chg);
   assign can_sleep = !pending && div_ff != 16'h0 && ien_ff[IEN_SLEEP]
                      && msr_ff == 4'h0 && RX_SERIAL_B && !wake_ev;
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         sl_ff <= SL_AWAKE;
      end else begin
         case (sl_ff)
            SL_AWAKE: if (can_sleep) begin
               sl_ff <= SL_ASLEEP;
            end
            SL_ASLEEP: if (wake_ev || !ien_ff[IEN_SLEEP]) begin
               sl_ff <= SL_AWAKE;
            end
            default: sl_ff <= SL_AWAKE;
         endcase
      end
   end
   assign OSC_RUN = sl_ff == SL_AWAKE;

   // wake raised wins over the clearing read of the source register
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         wake_int_ff <= 1'b0;
      end else if (sl_ff == SL_ASLEEP && wake_ev) begin
         wake_int_ff <= 1'b1;
      end else if (rd_go && S_AXI_ARADDR == A_ISRC) begin
         wake_int_ff <= 1'b0;
      end
   end

   // ***********************************
   // charge pump
   // ***********************************
   logic [31:0] idle_ff, rec_ff;
   logic pump_off_ff, pump_ev;
   assign pump_ev = rx_fall | (wr_go && wa == A_DATA) | modem_rise;
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         idle_ff <= 32'h0;
         pump_off_ff <= 1'b0;
      end else if (!PUMP_SHUTDOWN_ENABLE_PIN || pump_ev) begin
         idle_ff <= 32'h0;
         pump_off_ff <= 1'b0;
      end else if (sl_ff == SL_AWAKE) begin
         if (TX_ACTIVE || |modem_chg) begin
            idle_ff <= 32'h0;
         end else if (idle_ff >= 32'(IDLE_CYCLES - 1)) begin
            pump_off_ff <= 1'b1;
         end else begin
            idle_ff <= idle_ff + 32'h1;
         end
      end
   end
   // ready drops for the recovery time after each restart
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rec_ff <= 32'h0;
      end else if (pump_off_ff) begin
         rec_ff <= 32'(RECOVER_CYCLES);
      end else if (rec_ff != 32'h0) begin
         rec_ff <= rec_ff - 32'h1;
      end
   end
   assign PUMP_ON = ~pump_off_ff;
   assign PUMP_READY = ~pump_off_ff && rec_ff == 32'h0;
   assign LINE_DRV_OE_N = pump_off_ff;

   // ***********************************
   // automatic pause and resume sender
   // ***********************************
   logic [31:0] tmr_ff;
   logic sent_p_ff, kind_ff, idx_ff;
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ap_ff <= AP_IDLE;
         tmr_ff <= 32'h0;
         sent_p_ff <= 1'b0;
         kind_ff <= 1'b0;
         idx_ff <= 1'b0;
      end else begin
         case (ap_ff)
            AP_IDLE: begin
               idx_ff <= 1'b0;
               if (flow_ff[FLOW_AUTO] && !sent_p_ff && over_trig) begin
                  ap_ff <= AP_WAIT;
                  tmr_ff <= 32'(div_ff) * 32'(TWO_CHAR_MUL);
               end else if (sent_p_ff && under_res) begin
                  ap_ff <= AP_SEND;
                  kind_ff <= 1'b1;
               end
            end
            AP_WAIT: begin
               if (tmr_ff <= 32'h1) begin
                  ap_ff <= AP_SEND;
                  kind_ff <= 1'b0;
               end else begin
                  tmr_ff <= tmr_ff - 32'h1;
               end
            end
            AP_SEND: if (TX_FC_TAKEN) begin
               if (flow_ff[FLOW_DBL] && !idx_ff) begin
                  idx_ff <= 1'b1;
               end else begin
                  ap_ff <= AP_IDLE;
                  sent_p_ff <= ~kind_ff;
               end
            end
            default: ap_ff <= AP_IDLE;
         endcase
      end
   end
   // the transmitter gives this priority over its fifo at the next boundary
   assign TX_FC_VALID = ap_ff == AP_SEND;
   always_comb begin
      if (kind_ff) begin
         TX_FC_CHAR = idx_ff ? rchr_ff[15:8] : rchr_ff[7:0];
      end else begin
         TX_FC_CHAR = idx_ff ? pchr_ff[15:8] : pchr_ff[7:0];
      end
   end
endmodule
`default_nettype wire

// ===== bench/urf_monitor.sv
`default_nettype none
module urf_monitor import urf_pkg::*; (
   // clock, reset and bus
   input wire logic SYS_CLK, RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
   input wire logic [7:0] S_AXI_AWADDR, TX_HOLD_DATA, TX_FC_CHAR,
   input wire logic [31:0] S_AXI_WDATA,
   // line side and power
   input wire logic RX_SOURCE_SELECT, LINE_RX_DATA, CHANNEL_B_RECEIVE_INPUT, RX_SERIAL_B,
   input wire logic LINE_RX_TRISTATE, TX_HOLD_WRITE, TX_FC_VALID, TX_FC_TAKEN, INT_OUT,
   input wire logic PUMP_SHUTDOWN_ENABLE_PIN, OSC_RUN, PUMP_ON, PUMP_READY
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // properties
   // ****
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   property p_src;
      RX_SERIAL_B == (RX_SOURCE_SELECT ? CHANNEL_B_RECEIVE_INPUT : LINE_RX_DATA);
   endproperty
   a_src: assert property (p_src) else $error("wrong channel b source");
   property p_tri;
      LINE_RX_TRISTATE == RX_SOURCE_SELECT;
   endproperty
   a_tri: assert property (p_tri) else $error("line receiver tristate wrong");
   // a write to the data word must reach the transmitter and wake the oscillator
   property p_thr;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && S_AXI_AWADDR == A_DATA
      |-> ##2 TX_HOLD_WRITE && TX_HOLD_DATA == $past(S_AXI_WDATA[7:0], 2) ##[0:4] OSC_RUN;
   endproperty
   a_thr: assert property (p_thr) else $error("transmit write lost");
   property p_sleep;
      $fell(OSC_RUN) |-> !$past(INT_OUT);
   endproperty
   a_sleep: assert property (p_sleep) else $error("slept with interrupt");
   property p_shut;
      $fell(PUMP_ON) |-> $past(PUMP_SHUTDOWN_ENABLE_PIN);
   endproperty
   a_shut: assert property (p_shut) else $error("pump stopped without enable");
   property p_rec;
      $rose(PUMP_ON) |-> !PUMP_READY [*8];
   endproperty
   a_rec: assert property (p_rec) else $error("pump ready too soon");
   property p_rdy;
      PUMP_READY |-> PUMP_ON;
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready while pump off");
   property p_fc;
      TX_FC_VALID && !TX_FC_TAKEN |=> TX_FC_VALID && $stable(TX_FC_CHAR);
   endproperty
   a_fc: assert property (p_fc) else $error("flow character withdrawn");
   c_sleep: cover property ($fell(OSC_RUN));
   c_pump: cover property ($fell(PUMP_ON));
   c_fc: cover property (TX_FC_VALID && TX_FC_TAKEN);
endmodule
bind urf_uart_rx_fc_sleep urf_monitor mon (.*);
`default_nettype wire

// ===== bench/urf_partner.sv
`default_nettype none
module urf_partner import urf_pkg::*; (
   input wire logic clk, rst, fc_valid,
   input wire logic [7:0] fc_char,
   output urf_char_type rx_char,
   output logic rx_valid, fc_taken, tx_active,
   output logic [7:0] last_fc
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // slow transmitter and remote station
   // ****
   logic [1:0] wait_ff;
   initial {rx_char, rx_valid, fc_taken, tx_active, wait_ff, last_fc} = '0;
   always @(posedge clk) begin
      wait_ff <= (fc_valid && !fc_taken) ? wait_ff + 2'h1 : 2'h0;
      fc_taken <= fc_valid && !fc_taken && wait_ff == 2'h2 && !rst;
      if (fc_taken) last_fc <= fc_char;
      tx_active <= fc_valid;
   end
   task send(input urf_char_type c);
      @(posedge clk);
      rx_char <= c;
      rx_valid <= 1;
      @(posedge clk);
      rx_valid <= 0;
      rx_char <= ~c; // stale data must not look valid
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ===== bench/urf_uart_rx_fc_sleep_test.sv
`default_nettype none
module urf_uart_rx_fc_sleep_test import urf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
`define WT(c) begin @(negedge SYS_CLK); for (int i = 0; i < 400 && !(c); i++) \
   @(negedge SYS_CLK); end
   logic SYS_CLK = 0, RST = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
   logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, RX_SOURCE_SELECT = 0, LINE_RX_DATA = 1;
   logic CHANNEL_B_RECEIVE_INPUT = 1, PUMP_SHUTDOWN_ENABLE_PIN = 0;
   logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
   logic [31:0] S_AXI_WDATA = 0, d;
   logic [3:0] S_AXI_WSTRB = 4'hF, MODEM_IN = 0;
   logic [1:0] r;
   wire logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, INT_OUT;
   wire logic RX_SERIAL_B, LINE_RX_TRISTATE, TX_HOLD_WRITE, TX_HALT, TX_FC_VALID, TX_FC_TAKEN;
   wire logic TX_ACTIVE, RX_CHAR_VALID, OSC_RUN, PUMP_ON, PUMP_READY, LINE_DRV_OE_N;
   wire logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   wire logic [31:0] S_AXI_RDATA;
   wire logic [7:0] TX_HOLD_DATA, TX_FC_CHAR;
   urf_char_type RX_CHAR;
   int fails = 0, cmp_count = 0, cyc = 0;
   urf_uart_rx_fc_sleep #(.IDLE_CYCLES(50), .RECOVER_CYCLES(10)) uut (.*);
   urf_partner pt (.clk(SYS_CLK), .rst(RST), .fc_valid(TX_FC_VALID), .fc_char(TX_FC_CHAR),
      .rx_char(RX_CHAR), .rx_valid(RX_CHAR_VALID), .fc_taken(TX_FC_TAKEN),
      .tx_active(TX_ACTIVE), .last_fc());
   // ****
   // bus master and run control
   // ****
   initial forever #4 SYS_CLK = ~SYS_CLK;
   always @(posedge SYS_CLK) if (++cyc == 30000) begin fails++; tally_and_finish; end
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      @(posedge SYS_CLK);
      {S_AXI_AWADDR, S_AXI_WDATA} <= {a, v};
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
      do begin
         @(negedge SYS_CLK);
         {ta, tw, tb, r} = {S_AXI_AWVALID & S_AXI_AWREADY, S_AXI_WVALID & S_AXI_WREADY,
            S_AXI_BVALID, S_AXI_BRESP};
         @(posedge SYS_CLK);
         if (ta) S_AXI_AWVALID <= 0;
         if (tw) S_AXI_WVALID <= 0;
      end while (!tb);
      S_AXI_BREADY <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      @(posedge SYS_CLK);
      {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'h3};
      do begin
         @(negedge SYS_CLK);
         {ta, tr, d, r} = {S_AXI_ARVALID & S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RDATA, S_AXI_RRESP};
         @(posedge SYS_CLK);
         if (ta) S_AXI_ARVALID <= 0;
      end while (!tr);
      S_AXI_RREADY <= 0;
   endtask
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ****
   // scenarios
   // ****
   task t_regs_sel;
      rd(A_PCHR); `CHK(d[15:0], 16'h0000)
      rd(A_RCHR); `CHK(d[15:0], 16'h0000)
      rd(8'hFC); `CHK(r, RESP_ERR)
      wr(8'hFC, 32'h0); `CHK(r, RESP_ERR)
      for (int s = 0; s < 4; s++) begin
         @(posedge SYS_CLK);
         {RX_SOURCE_SELECT, LINE_RX_DATA, CHANNEL_B_RECEIVE_INPUT} <= {s[1], s[0], !s[0]};
         @(negedge SYS_CLK);
         `CHK(RX_SERIAL_B, s[1] ^ s[0])
         `CHK(LINE_RX_TRISTATE, s[1])
      end
      {RX_SOURCE_SELECT, LINE_RX_DATA, CHANNEL_B_RECEIVE_INPUT} <= 3'h3;
      $display("registers and source select done");
   endtask
   task t_fifo_sleep;
      wr(A_FCTL, 32'h1); `CHK(r, RESP_OK)
      pt.send({3'h1, 8'hA1});
      pt.send({3'h4, 8'hB2});
      rd(A_LSTAT); `CHK(d[4:2], 3'h1)
      rd(A_DATA); `CHK(d[7:0], 8'hA1)
      rd(A_LSTAT); `CHK(d[4:2], 3'h4)
      rd(A_DATA); `CHK(d[7:0], 8'hB2)
      wr(A_DIV, 32'h1);
      wr(A_IEN, 32'h1 << IEN_SLEEP);
      `WT(OSC_RUN === 0) `CHK(OSC_RUN, 0)
      wr(A_DATA, 32'h55);
      `WT(OSC_RUN === 1) `CHK(OSC_RUN, 1)
      `CHK(INT_OUT, 1)
      rd(A_ISRC); `CHK(d[3:0], ISRC_NONE)
      `WT(OSC_RUN === 0) `CHK(OSC_RUN, 0)
      wr(A_IEN, 32'h0);
      repeat (20) @(negedge SYS_CLK);
      `CHK(OSC_RUN, 1)
      $display("fifo and sleep done");
   endtask
   task t_pump;
      PUMP_SHUTDOWN_ENABLE_PIN <= 1;
      `WT(PUMP_ON === 0) `CHK(LINE_DRV_OE_N, 1)
      rd(A_DIV); `CHK(d[15:0], 16'h0001)
      MODEM_IN <= 4'h1;
      `WT(PUMP_ON === 1) `CHK(PUMP_READY, 0)
      `WT(PUMP_READY === 1) `CHK(PUMP_READY, 1)
      {PUMP_SHUTDOWN_ENABLE_PIN, MODEM_IN} <= 5'h00;
      rd(A_MSTAT); `CHK(d[3:0], 4'h1)
      $display("pump done");
   endtask
   task t_flow;
      wr(A_PCHR, 32'h1413);
      wr(A_RCHR, 32'h1211);
      wr(A_IEN, 32'h1 << IEN_PAUSE | 32'h1 << IEN_RXD);
      for (int m = 0; m < 2; m++) begin
         wr(A_FLOW, 32'h1 | (m << FLOW_DBL));
         pt.send({3'h0, 8'h13});
         if (m) pt.send({3'h0, 8'h14});
         `WT(TX_HALT === 1) `CHK(INT_OUT, 1)
         rd(A_ISRC); `CHK(d[ISRC_FC], 1'h1)
         pt.send({3'h0, 8'h11});
         if (m) pt.send({3'h0, 8'h12});
         `WT(TX_HALT === 0) `CHK(TX_HALT, 0)
         rd(A_ISRC); `CHK(d[ISRC_FC], 1'h0)
         rd(A_LSTAT); `CHK(d[0], 1'h0)
      end
      wr(A_FLOW, 32'h5);
      wr(A_FCTL, 32'h11);
      for (int k = 0; k < 8; k++) begin
         `CHK(INT_OUT, 0)
         pt.send({3'h0, 8'(k)});
      end
      `CHK(INT_OUT, 1)
      repeat (300) @(negedge SYS_CLK);
      `CHK(pt.last_fc, 8'h00)
      `WT(pt.last_fc === 8'h13) `CHK(pt.last_fc, 8'h13)
      for (int k = 0; k < 8; k++) begin
         rd(A_DATA); `CHK(d[7:0], 8'(k))
      end
      `WT(pt.last_fc === 8'h11) `CHK(pt.last_fc, 8'h11)
      $display("flow control done");
   endtask
   initial begin
      repeat (16) @(posedge SYS_CLK);
      RST <= 0;
      t_regs_sel;
      t_fifo_sleep;
      t_pump;
      t_flow;
      tally_and_finish;
   end
endmodule
`default_nettype wire
